// File: rtl/vtr_pkg.sv
// package: register map, reset values, field positions and timing constants of the video timer
package vtr_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADR_MODE0 = 8'h00;
  localparam logic [7:0] ADR_MODE1 = 8'h04;
  localparam logic [7:0] ADR_MODE2 = 8'h08;
  localparam logic [7:0] ADR_MODE4 = 8'h0C;
  localparam logic [7:0] ADR_MODE5 = 8'h10;
  localparam logic [7:0] ADR_MODE6 = 8'h14;
  localparam logic [7:0] ADR_MODE7 = 8'h18;
  localparam logic [7:0] ADR_TSEL = 8'h1C;
  localparam logic [7:0] ADR_SCFREQ = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;
  // values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MODE1 = 8'h07;
  localparam logic [7:0] RST_MODE2 = 8'h08;
  // field positions
  localparam int MODE0_STD_BIT = 0;
  localparam int MODE0_NONINT_BIT = 1;
  localparam int MODE2_PED_BIT = 3;
  localparam int MODE2_OVR_BIT = 5;
  localparam int MODE2_PASS_BIT = 6;
  localparam int MODE2_SLEEP_BIT = 7;
  localparam int MODE4_LOCKLO_BIT = 1;
  localparam int MODE4_LOCKHI_BIT = 2;
  localparam int MODE5_PORCH_BIT = 7;
  localparam int MODE5_DIR_BIT = 6;
  localparam int MODE6_HANDOVER_BIT = 0;
  localparam int MODE7_SYNCSEL_BIT = 5;
  localparam int TSEL_BLANKEN_BIT = 3;
  localparam logic [2:0] TSEL_MASTER3 = 3'h7;
  localparam logic [1:0] LOCK_DEFAULT = 2'h0;
  localparam logic [1:0] LOCK_PHASE_RESET = 2'h1;
  // line timing at the 50 ns clock
  localparam int CLK_NS = 50;
  localparam int LINE_NS_525 = 63556;
  localparam int LINE_NS_625 = 64000;
  localparam int HSYNC_NS = 4700;
  localparam int HBLANK_NS = 10700;
  localparam int FPORCH_NS = 1500;
  localparam int BURST_START_NS = 5300;
  localparam int BURST_NS = 2500;
  localparam logic [10:0] LINE_CLKS_525 = 11'(LINE_NS_525 / CLK_NS);
  localparam logic [10:0] LINE_CLKS_625 = 11'(LINE_NS_625 / CLK_NS);
  localparam logic [10:0] HSYNC_CLKS = 11'((HSYNC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] HBLANK_CLKS = 11'((HBLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] FPORCH_CLKS = 11'((FPORCH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] BURST_START_CLKS = 11'((BURST_START_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] BURST_CLKS = 11'(BURST_NS / CLK_NS);
  localparam logic [10:0] CLAMP_BP_OFS = 11'h004;
  localparam logic [10:0] CLAMP_FP_OFS = 11'h014;
  localparam logic [10:0] CLAMP_CLKS = 11'h004;
  // frame geometry
  localparam logic [9:0] LINES_525I = 10'h20D;
  localparam logic [9:0] LINES_525P = 10'h106;
  localparam logic [9:0] LINES_625I = 10'h271;
  localparam logic [9:0] LINES_625P = 10'h138;
  localparam logic [9:0] FIELD2_525 = 10'h108;
  localparam logic [9:0] FIELD2_625 = 10'h139;
  localparam logic [2:0] FSEQ_LAST_525 = 3'h3;
  localparam logic [2:0] FSEQ_LAST_625 = 3'h7;
  localparam logic [7:0] BLACK_CODE = 8'h10;
  typedef enum logic [1:0] {SEQ_INIT = 2'h0, SEQ_BLACK = 2'h1, SEQ_LIVE = 2'h3} vtr_seq_type;
  typedef struct packed {
    logic line_sync_n;
    logic field;
    logic blank_n;
  } vtr_strobe_type;
endpackage : vtr_pkg

// File: rtl/vtr_timing.sv
// video timing generator: reset sequencing, sync, blank, burst, clamp and wishbone registers
`timescale 1ns/100ps
// Overview of operation
// [R1] timing select 110 slave, 111 master
// [R2] field change, line sync high: new frame
// [R3] blank input optional, else self blanking
// [R4] slave follows strobes, master drives them
// [R5] 525 interlaced vsync and caption blank lines
// [R6] 525 interlaced burst suppression lines
// [R7] 525 noninterlaced blank, vsync, burst lines
// [R8] 625 interlaced blank lines per field group
// [R9] 625 interlaced burst suppression per group
// [R10] 625 noninterlaced blank, vsync, burst lines
// [R11] reset deselects the pixel inputs
// [R12] standard pin picks standard, preloads subcarrier
// [R13] registers clear, mode1 07H, mode2 08H
// [R14] reset: dacs D,E,F on, pass clear
// [R15] black level, strobes off until pass
// [R16] override bit takes standard from register
// [R17] strap sleep, handover to register bit
// [R18] periodic phase reset every 4/8 fields
// [R19] host avoids resets with unstable source
// [R20] phase reset applies at next field
// [R21] sync outputs, shared hsync/csync pin
// [R22] clamp porch select and 1-3 shift
// [R23] pin rising edge requests phase reset
// [R24] field sequence wraps at 4 or 8
module vtr_timing #(
  parameter logic [31:0] SC_FREQ_525 = 32'h2000_0000,
  parameter logic [31:0] SC_FREQ_625 = 32'h2800_0000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  input wire logic standard_select_pin,
  input wire logic subcarrier_reset_pin,
  input wire logic [7:0] pixel_in_bus,
  input wire vtr_pkg::vtr_strobe_type strobe_in,
  output vtr_pkg::vtr_strobe_type strobe_out,
  output vtr_pkg::vtr_strobe_type strobe_oe_n,
  output logic [7:0] pixel_out,
  output logic pixel_sel,
  output logic [5:0] dac_en,
  output logic pedestal_enable,
  output logic sleep_out,
  output logic std_625_out,
  output logic video_blank,
  output logic burst_en,
  output logic sync_pin_n,
  output logic vertical_sync_out_n,
  output logic clamp_out,
  output logic [31:0] sc_phase
);
  import vtr_pkg::*;

  logic [7:0] mode0, mode1, mode2, mode4, mode5, mode6, mode7, timing_select_reg;
  logic [31:0] sc_freq;
  vtr_seq_type seq;
  logic sleep_strap, sync_in_q, field_in_q, sc_pin_q, sc_pend;
  logic [10:0] pix_cnt, next_pix, line_clks, clamp_pos;
  logic [9:0] line_cnt, next_line, line_total, field2_line;
  logic [2:0] fseq, next_fseq, fseq_last;
  logic bus_req, wr8, master, std_625, nonint, pixel_pass_enable, live, line_step;
  logic sync_fall, frame_mark, field_start, pend_apply, phase_zero, sc_rise;
  logic horizontal_sync_out, composite_sync_out, vline_c, hblank_c, blank_c, burst_c, clamp_c;
  logic [1:0] lock_mode;
  logic [31:0] rd_data;

  // true when l lies in lo..hi inclusive
  function automatic logic in_rng(input logic [9:0] l, input logic [9:0] lo,
                                  input logic [9:0] hi);
    return (l >= lo) && (l <= hi);
  endfunction : in_rng

  // [R5] [R7] [R8] [R10] vsync lines, grp_b marks fields 3,4,7,8
  function automatic logic vsync_line(input logic [9:0] l, input logic p625, input logic np,
                                      input logic grp_b);
    logic r;
    if (!p625) r = in_rng(l, 10'h001, 10'h009) | (!np & in_rng(l, 10'h108, 10'h110));
    else if (np) r = in_rng(l, 10'h001, 10'h006) | in_rng(l, 10'h137, 10'h138);
    else if (grp_b) r = in_rng(l, 10'h001, 10'h005) | in_rng(l, 10'h137, 10'h13F) |
                        in_rng(l, 10'h270, 10'h271);
    else r = in_rng(l, 10'h001, 10'h006) | in_rng(l, 10'h137, 10'h13E) |
             in_rng(l, 10'h270, 10'h271);
    return r;
  endfunction : vsync_line

  // [R6] [R7] [R9] [R10] lines with burst suppressed
  function automatic logic burst_off(input logic [9:0] l, input logic p625, input logic np,
                                     input logic grp_b);
    logic r;
    if (!p625) r = in_rng(l, 10'h001, 10'h006) | (np ? in_rng(l, 10'h105, 10'h106) :
                   (in_rng(l, 10'h105, 10'h10D) | in_rng(l, 10'h20B, 10'h20D)));
    else if (np) r = in_rng(l, 10'h001, 10'h005) | in_rng(l, 10'h136, 10'h138);
    else if (grp_b) r = in_rng(l, 10'h001, 10'h005) | in_rng(l, 10'h137, 10'h13F) |
                        in_rng(l, 10'h26F, 10'h271);
    else r = in_rng(l, 10'h001, 10'h006) | in_rng(l, 10'h137, 10'h13E) |
             in_rng(l, 10'h26F, 10'h271);
    return r;
  endfunction : burst_off

  // [R5] [R8] [R10] whole blanking interval, caption and teletext lines too
  function automatic logic vbi_line(input logic [9:0] l, input logic p625, input logic np);
    logic r;
    if (!p625) r = in_rng(l, 10'h001, 10'h015) |
                   (!np & (in_rng(l, 10'h106, 10'h11C) | (l == 10'h20D)));
    else r = in_rng(l, 10'h001, 10'h016) | (np ? in_rng(l, 10'h136, 10'h138) :
             (in_rng(l, 10'h137, 10'h14F) | in_rng(l, 10'h270, 10'h271)));
    return r;
  endfunction : vbi_line

  // operating mode decode
  // [R1] master only on 111
  assign master = (timing_select_reg[2:0] == TSEL_MASTER3);
  // [R16] override picks standard
  assign std_625 = mode2[MODE2_OVR_BIT] ? mode0[MODE0_STD_BIT] : standard_select_pin;
  assign nonint = mode0[MODE0_NONINT_BIT];
  assign pixel_pass_enable = mode2[MODE2_PASS_BIT];
  assign lock_mode = {mode4[MODE4_LOCKHI_BIT], mode4[MODE4_LOCKLO_BIT]};
  assign live = (seq == SEQ_LIVE);
  assign line_clks = std_625 ? LINE_CLKS_625 : LINE_CLKS_525;
  assign line_total = std_625 ? (nonint ? LINES_625P : LINES_625I) :
                                (nonint ? LINES_525P : LINES_525I);
  assign field2_line = std_625 ? FIELD2_625 : FIELD2_525;
  // [R24] wrap point per standard
  assign fseq_last = std_625 ? FSEQ_LAST_625 : FSEQ_LAST_525;

  // incoming strobe edges; inputs already sit in the mclk domain
  assign sync_fall = sync_in_q & ~strobe_in.line_sync_n;
  // [R2] field change with line sync high marks a frame
  assign frame_mark = ~master & (strobe_in.field != field_in_q) & strobe_in.line_sync_n;

  // [R4] pixel and line counters: free running or slaved to strobes
  always_comb begin
    next_pix = (pix_cnt == 11'h7FF) ? pix_cnt : pix_cnt + 11'h001;
    line_step = 1'b0;
    if (master) begin
      if (pix_cnt >= line_clks - 11'h001) begin
        next_pix = 11'h000;
        line_step = 1'b1;
      end
    end else if (sync_fall) begin
      next_pix = 11'h000;
      line_step = 1'b1;
    end
    next_line = line_cnt;
    if (line_step) begin
      next_line = (line_cnt >= line_total) ? 10'h001 : line_cnt + 10'h001;
    end
    if (frame_mark) begin
      next_line = 10'h001;
    end
  end

  assign field_start = (line_step | frame_mark) &
                       ((next_line == 10'h001) | (~nonint & (next_line == field2_line)));
  // [R23] pin edge counts only in phase-reset mode
  assign sc_rise = subcarrier_reset_pin & ~sc_pin_q & (lock_mode == LOCK_PHASE_RESET);
  assign pend_apply = sc_pend & (lock_mode == LOCK_PHASE_RESET);
  // [R24] field sequence advance and wrap
  assign next_fseq = (pend_apply || fseq >= fseq_last) ? 3'h0 : fseq + 3'h1;
  // [R18] periodic reset only in the default lock mode
  assign phase_zero = pend_apply | ((lock_mode == LOCK_DEFAULT) & (next_fseq == 3'h0));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pix_cnt <= 11'h000;
      line_cnt <= 10'h001;
      sync_in_q <= 1'b1;
      field_in_q <= 1'b0;
      sc_pin_q <= 1'b0;
    end else begin
      pix_cnt <= next_pix;
      line_cnt <= next_line;
      sync_in_q <= strobe_in.line_sync_n;
      field_in_q <= strobe_in.field;
      sc_pin_q <= subcarrier_reset_pin;
    end
  end

  // [R20] pending phase reset waits for the next field; a new edge beats the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sc_pend <= 1'b0;
    end else if (sc_rise) begin
      sc_pend <= 1'b1;
    end else if (field_start) begin
      sc_pend <= 1'b0;
    end
  end

  // [R18] 32-bit synthesiser, phase back to field 0 value at a field start with phase_zero set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fseq <= 3'h0;
      sc_phase <= 32'h0000_0000;
    end else begin
      if (field_start) begin
        fseq <= next_fseq;
      end
      if (field_start && phase_zero) begin
        sc_phase <= 32'h0000_0000;
      end else begin
        sc_phase <= sc_phase + sc_freq;
      end
    end
  end

  // reset sequence: one cycle to catch straps, black until pass bit, then live
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq <= SEQ_INIT;
    end else begin
      unique case (seq)
        SEQ_INIT: seq <= SEQ_BLACK;
        // [R15] leave black only once pass is set
        SEQ_BLACK: if (pixel_pass_enable) seq <= SEQ_LIVE;
        SEQ_LIVE: if (!pixel_pass_enable) seq <= SEQ_BLACK;
        default: seq <= SEQ_INIT;
      endcase
    end
  end

  // line decode for the waveform sections
  always_comb begin
    horizontal_sync_out = (pix_cnt < HSYNC_CLKS);
    vline_c = vsync_line(line_cnt, std_625, nonint, fseq[1]);
    // coarse broad pulses: equalising halves are not shaped here
    composite_sync_out = vline_c ? ~horizontal_sync_out : horizontal_sync_out;
    hblank_c = (pix_cnt < HBLANK_CLKS) | (pix_cnt >= line_clks - FPORCH_CLKS);
    blank_c = vbi_line(line_cnt, std_625, nonint) | hblank_c;
    // [R3] external blank only when enabled in slave mode
    if (!master && timing_select_reg[TSEL_BLANKEN_BIT]) begin
      blank_c = ~strobe_in.blank_n;
    end
    burst_c = (pix_cnt >= BURST_START_CLKS) & (pix_cnt < BURST_START_CLKS + BURST_CLKS) &
              ~burst_off(line_cnt, std_625, nonint, fseq[1]);
  end

  // [R22] clamp position from porch select and signed shift
  always_comb begin
    clamp_pos = mode5[MODE5_PORCH_BIT] ? line_clks - CLAMP_FP_OFS : HSYNC_CLKS + CLAMP_BP_OFS;
    if (mode5[MODE5_DIR_BIT]) begin
      clamp_pos = clamp_pos - {9'h000, mode5[5:4]};
    end else begin
      clamp_pos = clamp_pos + {9'h000, mode5[5:4]};
    end
    clamp_c = (pix_cnt >= clamp_pos) & (pix_cnt < clamp_pos + CLAMP_CLKS);
  end

  // analog-side timing runs from release; blank and burst never stop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      video_blank <= 1'b1;
      burst_en <= 1'b0;
      clamp_out <= 1'b0;
    end else begin
      video_blank <= blank_c;
      burst_en <= burst_c;
      clamp_out <= clamp_c;
    end
  end

  // [R21] digital sync outputs, suppressed until live
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_pin_n <= 1'b1;
      vertical_sync_out_n <= 1'b1;
    end else if (!live) begin
      sync_pin_n <= 1'b1;
      vertical_sync_out_n <= 1'b1;
    end else begin
      sync_pin_n <= mode7[MODE7_SYNCSEL_BIT] ? ~composite_sync_out : ~horizontal_sync_out;
      vertical_sync_out_n <= ~vline_c;
    end
  end

  // [R4] master drives the strobes; released pins idle high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strobe_out <= '1;
      strobe_oe_n <= '1;
    end else if (master && live) begin
      strobe_out.line_sync_n <= ~horizontal_sync_out;
      strobe_out.field <= fseq[0];
      strobe_out.blank_n <= ~blank_c;
      strobe_oe_n <= '0;
    end else begin
      strobe_out <= '1;
      strobe_oe_n <= '1;
    end
  end

  // [R11] pixel port deselected in reset, black level until live
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pixel_out <= BLACK_CODE;
      pixel_sel <= 1'b0;
    end else begin
      pixel_out <= live ? pixel_in_bus : BLACK_CODE;
      pixel_sel <= live;
    end
  end

  // [R14] dac enables follow mode1, D,E,F on through reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_en <= RST_MODE1[5:0];
      pedestal_enable <= RST_MODE2[MODE2_PED_BIT];
      sleep_out <= 1'b0;
      std_625_out <= 1'b0;
    end else begin
      dac_en <= mode1[5:0];
      pedestal_enable <= mode2[MODE2_PED_BIT];
      // [R17] strap sleep until handed to the register bit
      sleep_out <= mode6[MODE6_HANDOVER_BIT] ? mode2[MODE2_SLEEP_BIT] : sleep_strap;
      std_625_out <= std_625;
    end
  end

  // wishbone: answer one cycle after the strobe, ack drops the next cycle
  assign bus_req = wb_cyc & wb_stb & ~wb_ack;
  assign wr8 = bus_req & wb_we & wb_sel[0];

  always_comb begin
    unique case (wb_adr)
      ADR_MODE0: rd_data = {24'h000000, mode0};
      ADR_MODE1: rd_data = {24'h000000, mode1};
      ADR_MODE2: rd_data = {24'h000000, mode2};
      ADR_MODE4: rd_data = {24'h000000, mode4};
      ADR_MODE5: rd_data = {24'h000000, mode5};
      ADR_MODE6: rd_data = {24'h000000, mode6};
      ADR_MODE7: rd_data = {24'h000000, mode7};
      ADR_TSEL: rd_data = {24'h000000, timing_select_reg};
      ADR_SCFREQ: rd_data = sc_freq;
      ADR_STATUS: rd_data = {14'h0000, fseq, line_cnt, live, sleep_out, std_625, sc_pend, master};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // [R13] register file with documented reset values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode0 <= RST_ZERO;
      mode1 <= RST_MODE1;
      mode2 <= RST_MODE2;
      mode4 <= RST_ZERO;
      mode5 <= RST_ZERO;
      mode6 <= RST_ZERO;
      mode7 <= RST_ZERO;
      timing_select_reg <= RST_ZERO;
      sc_freq <= 32'h0000_0000;
      sleep_strap <= 1'b0;
    end else if (seq == SEQ_INIT) begin
      // [R12] straps caught after release, not under reset
      sc_freq <= standard_select_pin ? SC_FREQ_625 : SC_FREQ_525;
      sleep_strap <= subcarrier_reset_pin & standard_select_pin;
    end else begin
      if (wr8 && wb_adr == ADR_MODE0) mode0 <= wb_dat_i[7:0];
      if (wr8 && wb_adr == ADR_MODE1) mode1 <= wb_dat_i[7:0];
      if (wr8 && wb_adr == ADR_MODE2) mode2 <= wb_dat_i[7:0];
      if (wr8 && wb_adr == ADR_MODE4) mode4 <= wb_dat_i[7:0];
      if (wr8 && wb_adr == ADR_MODE5) mode5 <= wb_dat_i[7:0];
      if (wr8 && wb_adr == ADR_MODE6) mode6 <= wb_dat_i[7:0];
      if (wr8 && wb_adr == ADR_MODE7) mode7 <= wb_dat_i[7:0];
      if (wr8 && wb_adr == ADR_TSEL) timing_select_reg <= wb_dat_i[7:0];
      for (int b = 0; b < 4; b++) begin
        if (bus_req && wb_we && wb_sel[b] && wb_adr == ADR_SCFREQ) begin
          sc_freq[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // checks
  a_master_drive: assert property (@(posedge mclk) disable iff (rst) // [R1]
    (timing_select_reg[2:0] != TSEL_MASTER3) |=> (strobe_oe_n == '1))
    else $error("strobes driven outside master mode");
  a_frame_mark: assert property (@(posedge mclk) disable iff (rst) // [R2]
    (!master && strobe_in.field != field_in_q && strobe_in.line_sync_n) |=> line_cnt == 10'h001)
    else $error("field change with sync high did not restart frame");
  a_self_blank: assert property (@(posedge mclk) disable iff (rst) // [R3]
    (!master && !timing_select_reg[TSEL_BLANKEN_BIT] && !std_625 && !nonint &&
     line_cnt >= 10'h00A && line_cnt <= 10'h015) |=> video_blank)
    else $error("caption line not blanked");
  a_vsync_lines: assert property (@(posedge mclk) disable iff (rst) // [R5]
    (live && !std_625 && !nonint && (line_cnt <= 10'h009 || line_cnt >= 10'h108) &&
     line_cnt <= 10'h110 && pixel_pass_enable) |=> !vertical_sync_out_n)
    else $error("vertical sync missing on a sync line");
  a_burst_gap: assert property (@(posedge mclk) disable iff (rst) // [R6]
    (!std_625 && !nonint && (line_cnt <= 10'h006 || line_cnt >= 10'h105) &&
     line_cnt <= 10'h10D) |=> !burst_en)
    else $error("burst present on suppressed line");
  a_pass_gate: assert property (@(posedge mclk) disable iff (rst) // [R15]
    (!live) |=> (sync_pin_n && vertical_sync_out_n && pixel_out == BLACK_CODE && !pixel_sel))
    else $error("output active before pass enable");
  a_handover_sleep: assert property (@(posedge mclk) disable iff (rst) // [R17]
    mode6[MODE6_HANDOVER_BIT] |=> sleep_out == $past(mode2[MODE2_SLEEP_BIT]))
    else $error("sleep not following register after handover");
  a_phase_restore: assert property (@(posedge mclk) disable iff (rst) // [R20]
    (field_start && pend_apply) |=> (sc_phase == 32'h0000_0000 && fseq == 3'h0))
    else $error("requested phase reset not applied");
  a_fseq_wrap: assert property (@(posedge mclk) disable iff (rst) // [R24]
    (!std_625 && field_start && fseq == FSEQ_LAST_525) |=> fseq == 3'h0)
    else $error("field sequence did not wrap at four");
  a_clamp_width: assert property (@(posedge mclk) disable iff (rst) // [R22]
    ($rose(clamp_out) && pix_cnt < 11'h200) |-> clamp_out [*4] ##1 !clamp_out)
    else $error("clamp pulse width wrong");
  a_wb_ack_once: assert property (@(posedge mclk) disable iff (rst)
    (wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
    else $error("wishbone ack not a single cycle");
endmodule : vtr_timing

// File: tb/vtr_sync_src.sv
// partner: slave timing source driving line sync and field strobes
`timescale 1ns/100ps
module vtr_sync_src #(
  parameter int LINE = 1271,
  parameter int LINES = 26
) (
  input wire logic mclk,
  input wire logic rst,
  output vtr_pkg::vtr_strobe_type strobe,
  output int line_no,
  output int pix_no
);
  import vtr_pkg::*;
  // pixel and line count; a short frame keeps the run brief
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pix_no <= 0;
      line_no <= LINES;
    end else if (pix_no == LINE - 1) begin
      pix_no <= 0;
      line_no <= (line_no == LINES) ? 1 : line_no + 1;
    end else begin
      pix_no <= pix_no + 1;
    end
  end
  // field flips mid line one, sync high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strobe <= '1;
    end else begin
      strobe.line_sync_n <= !(pix_no == LINE - 1 || pix_no < 93);
      if (pix_no == 300 && line_no == 1) strobe.field <= !strobe.field;
    end
  end
endmodule : vtr_sync_src

// File: tb/video_timing_reset_control_tb.sv
// testbench: reset values, override, sleep, black start, slave frame, master strobes
`timescale 1ns/100ps
module video_timing_reset_control_tb;
  import vtr_pkg::*;
  localparam logic [31:0] F5 = 32'h1357_9BDF;  // arbitrary preset
  localparam logic [31:0] F6 = 32'h2468_ACE0;  // arbitrary preset
  logic mclk, rst, wb_cyc, wb_stb, wb_we, wb_ack, standard_select_pin, subcarrier_reset_pin;
  logic pixel_sel, pedestal_enable, sleep_out, std_625_out, video_blank, burst_en;
  logic sync_pin_n, vertical_sync_out_n, clamp_out;
  logic [7:0] wb_adr, pixel_in_bus, pixel_out, v, pv;
  logic [3:0] wb_sel;
  logic [5:0] dac_en;
  logic [31:0] wb_dat_i, wb_dat_o, sc_phase, q;
  vtr_strobe_type strobe_in, strobe_out, strobe_oe_n;
  int n_errors, tests_run, line_no, pix_no, cnt;
  int ls[8] = '{2, 4, 7, 9, 10, 21, 22, 25};
  vtr_timing #(.SC_FREQ_525(F5), .SC_FREQ_625(F6)) dut_u (
    .mclk(mclk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack(wb_ack), .standard_select_pin(standard_select_pin),
    .subcarrier_reset_pin(subcarrier_reset_pin), .pixel_in_bus(pixel_in_bus),
    .strobe_in(strobe_in), .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n),
    .pixel_out(pixel_out), .pixel_sel(pixel_sel), .dac_en(dac_en),
    .pedestal_enable(pedestal_enable), .sleep_out(sleep_out), .std_625_out(std_625_out),
    .video_blank(video_blank), .burst_en(burst_en), .sync_pin_n(sync_pin_n),
    .vertical_sync_out_n(vertical_sync_out_n), .clamp_out(clamp_out), .sc_phase(sc_phase));
  vtr_sync_src #(.LINE(1271), .LINES(26)) src_u (
    .mclk(mclk), .rst(rst), .strobe(strobe_in), .line_no(line_no), .pix_no(pix_no));
  // 20 MHz clock
  always #25 mclk = ~mclk;
  // expected line classes for 525 interlaced
  function automatic logic vs(input int l);
    return l <= 9 || (l >= 264 && l <= 272);
  endfunction : vs
  function automatic logic bl(input int l);
    return l <= 21 || (l >= 262 && l <= 284) || l == 525;
  endfunction : bl
  function automatic logic bu(input int l);
    return !(l <= 6 || (l >= 261 && l <= 269) || l >= 523);
  endfunction : bu
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    return a == ADR_MODE1 ? RST_MODE1 : (a == ADR_MODE2 ? RST_MODE2 : RST_ZERO);
  endfunction : exp_reg
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // classic cycle held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk);
  endtask : wb
  task automatic do_reset(input logic sp, input logic sc);
    standard_select_pin <= sp;
    subcarrier_reset_pin <= sc;
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("dac_en", 32'h07, 32'(dac_en));
    chk("pixel_sel", 32'h0, 32'(pixel_sel));
    chk("pedestal", 32'h1, 32'(pedestal_enable));
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : do_reset
  task automatic wait_at(input int l, input int p);
    int n;
    n = 0;
    while (!(line_no == l && pix_no == p) && n < 70000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 70000) n_errors++;
  endtask : wait_at
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // main sequence; stable source, so one phase-reset pin edge is allowed
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i, pixel_in_bus} = '0;
    wb_sel = 4'hF;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(27));
    do_reset(1'b1, 1'b1);
    chk("sleep", 32'h1, 32'(sleep_out));
    wb(1'b1, ADR_MODE6, 32'h01);
    wb(1'b1, ADR_MODE2, 32'h08);
    chk("sleep", 32'h0, 32'(sleep_out));
    wb(1'b1, ADR_MODE2, 32'h88);
    chk("sleep", 32'h1, 32'(sleep_out));
    $display("test sleep done");
    do_reset(1'($urandom), 1'b0);
    chk("std", 32'(standard_select_pin), 32'(std_625_out));
    wb(1'b0, ADR_SCFREQ, 32'h0);
    chk("scfreq", standard_select_pin ? F6 : F5, q);
    q = sc_phase;
    @(posedge mclk);
    chk("phase", q + (standard_select_pin ? F6 : F5), sc_phase);
    for (int a = 0; a < 8; a++) begin
      wb(1'b0, 8'(a * 4), 32'h0);
      chk("reg", 32'(exp_reg(8'(a * 4))), q);
    end
    wb(1'b0, 8'h28, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int i = 1; i >= 0; i--) begin
      wb(1'b1, ADR_MODE0, 32'(i));
      wb(1'b1, ADR_MODE2, 32'h28);
      chk("std", 32'(i), 32'(std_625_out));
    end
    $display("test reset done");
    cnt = 0;
    repeat (1300) begin
      @(posedge mclk);
      cnt += int'(sync_pin_n !== 1'b1) + int'(vertical_sync_out_n !== 1'b1);
      cnt += int'(pixel_out !== BLACK_CODE);
    end
    chk("quiet", 32'h0, 32'(cnt));
    wb(1'b1, ADR_MODE2, 32'h68);
    @(posedge mclk);
    chk("pixel_sel", 32'h1, 32'(pixel_sel));
    for (int i = 0; i < 20; i++) begin
      v = 8'($urandom);
      pixel_in_bus <= v;
      @(posedge mclk);
      if (i > 0) chk("pixel", 32'(pv), 32'(pixel_out));
      pv = v;
    end
    $display("test live done");
    wb(1'b1, ADR_MODE4, 32'h02);
    subcarrier_reset_pin <= 1'b1;
    @(posedge mclk);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("pend", 32'h1, 32'(q[1]));
    wb(1'b1, ADR_MODE7, 32'h20);
    wait_at(1, 320);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("line", 32'h1, 32'(q[14:5]));
    chk("pend", 32'h0, 32'(q[1]));
    foreach (ls[k]) begin
      wait_at(ls[k], 50);
      chk("csync", 32'(vs(ls[k])), 32'(sync_pin_n));
      wait_at(ls[k], HSYNC_CLKS + CLAMP_BP_OFS + 3);
      chk("clamp", 32'h1, 32'(clamp_out));
      wait_at(ls[k], 125);
      chk("burst", 32'(bu(ls[k])), 32'(burst_en));
      chk("clamp", 32'h0, 32'(clamp_out));
      wait_at(ls[k], 600);
      chk("blank", 32'(bl(ls[k])), 32'(video_blank));
      chk("vsync", 32'(!vs(ls[k])), 32'(vertical_sync_out_n));
    end
    $display("test slave frame done");
    wb(1'b1, ADR_TSEL, 32'(TSEL_MASTER3));
    repeat (1300) @(posedge mclk);
    chk("oe_n", 32'h0, 32'(strobe_oe_n));
    cnt = 0;
    repeat (int'(LINE_CLKS_525)) begin
      @(posedge mclk);
      cnt += int'(strobe_out.line_sync_n === 1'b0);
    end
    chk("sync_len", 32'(HSYNC_CLKS), 32'(cnt));
    $display("test master done");
    report_and_stop();
  end
  // watchdog: the tests need under 80000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule : video_timing_reset_control_tb
